// ---- hdl/tcss_pkg.sv ----
// Behaviour
// R1: With the frequency-range bit and the slow-clock bit both 0, codes 000B to 100B count on the system clock undivided, /2, /4, /8 and /32.
// R2: Code 101B counts edges of the external count clock pin, except with an X1 or PLL CPU clock and the slow-clock bit set.
// R3: Software must not use codes 001B to 100B while the frequency-range bit is 1.
// R4: With the slow-clock bit set and code 000B the counter runs on the slow clock; codes 001B to 100B are then prohibited.
// R5: Software uses code 000B with a PLL CPU clock and the range bit at 1 only if the PLL clock is at most 32 MHz.
// R6: Software starts the oscillator chosen as count source before writing the select bits.
// R7: Software must not select the external count clock pin in three-phase PWM mode.
// R8: In capture use, general register A holds the 16-bit capture value, counting follows the start bit and match flag A reports the event.
// R9: In compare use, the counter is compared with 16-bit general register B, a match sets match flag B and drives the compare output B pin.
// R10: Software clears the match flags itself; hardware never clears them.
// R11: In PWM use the output is active low and inactive high.
// R12: The counter advances by one per active edge of the selected source, only while the start bit is set.
package tcss_pkg;
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_GRA    = 4'h1;
  localparam logic [3:0] ADDR_GRB    = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_MASK   = 4'h4;
  localparam logic [3:0] ADDR_COUNT  = 4'h5;
  localparam logic [3:0] ADDR_CLKCFG = 4'h6;

  // CTRL fields
  localparam int CTRL_START_POS = 0;
  localparam int CTRL_MODE_POS  = 1;
  localparam int CTRL_SEL_POS   = 4;
  localparam int CTRL_SLOW_POS  = 7;
  localparam int CTRL_FRQ_POS   = 8;
  // CLKCFG field: cpu clock source code
  localparam int CPUSRC_POS     = 0;

  localparam int FLAG_A_POS     = 0;
  localparam int FLAG_B_POS     = 1;
  localparam int FLAG_ERR_POS   = 2;
  localparam int FLAG_W         = 3;

  localparam logic [2:0] SEL_DIV1 = 3'h0;
  localparam logic [2:0] SEL_DIV2 = 3'h1;
  localparam logic [2:0] SEL_DIV4 = 3'h2;
  localparam logic [2:0] SEL_DIV8 = 3'h3;
  localparam logic [2:0] SEL_DIV32 = 3'h4;
  localparam logic [2:0] SEL_EXT  = 3'h5;

  localparam logic [2:0] CPU_HOCO = 3'h0;
  localparam logic [2:0] CPU_LOCO = 3'h1;
  localparam logic [2:0] CPU_X1   = 3'h2;
  localparam logic [2:0] CPU_PLL  = 3'h3;
  localparam logic [2:0] CPU_XT1  = 3'h4;

  localparam logic [1:0] MODE_CAPTURE = 2'h0;
  localparam logic [1:0] MODE_COMPARE = 2'h1;
  localparam logic [1:0] MODE_PWM     = 2'h2;
  localparam logic [1:0] MODE_THREE_PHASE_PWM_MODE    = 2'h3;

  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] GR_RST    = 16'hFFFF;
  localparam logic [4:0]  PRESC_RST = 5'h00;
endpackage

// ---- hdl/tcss_edge.sv ----
`timescale 1ns/100ps
`default_nettype none
// Two-stage synchroniser with rising-edge pulse on the later stages
module tcss_edge (
  input  wire logic ref_clk_in,
  input  wire logic nrst_in,
  input  wire logic sig_in,
  output logic      rise_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } tcss_edge_s;
  tcss_edge_s st;
  tcss_edge_s next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = sig_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rise_out = st.s2 & ~st.s3;
endmodule
`default_nettype wire

// ---- hdl/tcss_timer.sv ----
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/100ps
`default_nettype none
module tcss_timer (
  input  wire logic        ref_clk_in,
  input  wire logic        nrst_in,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        ext_count_clock_pin_in,
  input  wire logic        slow_clock_in,
  input  wire logic        capture_in,
  output logic             compare_output_b_pin_out,
  output logic             irq_out
);
  typedef struct packed {
    logic        count_start_bit;
    logic [1:0]  mode;
    logic [2:0]  count_source_sel;
    logic        slow_clock_select_bit;
    logic        hoco_freq_range_bit;
    logic [2:0]  cpu_clock_status_sel;
    logic [15:0] general_reg_a;
    logic [15:0] general_reg_b;
    logic [15:0] count;
    logic [4:0]  presc;
    logic [tcss_pkg::FLAG_W-1:0] status;
    logic [tcss_pkg::FLAG_W-1:0] mask;
    logic        out_b;
    logic        irq;
    logic        ack;
    logic [31:0] rdata;
  } tcss_timer_s;

  tcss_timer_s st;
  tcss_timer_s next_st;
  logic        ext_rise;
  logic        slow_rise;
  logic        cap_rise;

  tcss_edge u_ext (
    .ref_clk_in (ref_clk_in),
    .nrst_in    (nrst_in),
    .sig_in     (ext_count_clock_pin_in),
    .rise_out   (ext_rise)
  );
  tcss_edge u_slow (
    .ref_clk_in (ref_clk_in),
    .nrst_in    (nrst_in),
    .sig_in     (slow_clock_in),
    .rise_out   (slow_rise)
  );
  tcss_edge u_cap (
    .ref_clk_in (ref_clk_in),
    .nrst_in    (nrst_in),
    .sig_in     (capture_in),
    .rise_out   (cap_rise)
  );

  logic       tick;
  logic       legal;
  logic       ext_ok;
  logic       wr;
  logic       rd;
  logic       match_a;
  logic       match_b;
  logic [4:0] next_presc;
  logic [tcss_pkg::FLAG_W-1:0] ev;

  always_comb begin
    next_st    = st;
    tick       = 1'b0;
    legal      = 1'b0;
    ev         = '0;
    next_presc = 5'(st.presc + 5'h01);
    // Writes land on the edge at which the master sees waitrequest low
    wr = avs_write & st.ack;
    rd = avs_read & ~st.ack;
    // External clock is denied with X1 or PLL CPU clock and slow select
    ext_ok = !(st.slow_clock_select_bit &&
      (st.cpu_clock_status_sel == tcss_pkg::CPU_X1 ||
       st.cpu_clock_status_sel == tcss_pkg::CPU_PLL));
    next_st.presc = next_presc;
    if (st.count_source_sel == tcss_pkg::SEL_EXT) begin
      tick  = ext_rise & ext_ok; // R2
      legal = ext_ok;
    end else if (st.slow_clock_select_bit) begin
      legal = (st.count_source_sel == tcss_pkg::SEL_DIV1);
      tick  = legal & slow_rise; // R4
    end else if (st.hoco_freq_range_bit) begin
      // High range: only undivided clock is usable
      legal = (st.count_source_sel == tcss_pkg::SEL_DIV1);
      tick  = legal;
    end else begin
      legal = 1'b1;
      unique case (st.count_source_sel) // R1
        tcss_pkg::SEL_DIV1:  tick = 1'b1;
        tcss_pkg::SEL_DIV2:  tick = (st.presc[0] == 1'b1);
        tcss_pkg::SEL_DIV4:  tick = (st.presc[1:0] == 2'h3);
        tcss_pkg::SEL_DIV8:  tick = (st.presc[2:0] == 3'h7);
        tcss_pkg::SEL_DIV32: tick = (st.presc == 5'h1F);
        default: begin
          tick  = 1'b0;
          legal = 1'b0;
        end
      endcase
    end
    // Three-phase PWM rejects the external source
    if (st.mode == tcss_pkg::MODE_THREE_PHASE_PWM_MODE &&
        st.count_source_sel == tcss_pkg::SEL_EXT) begin
      tick  = 1'b0;
      legal = 1'b0;
    end
    tick = tick & st.count_start_bit; // R12
    match_a = tick && (st.count == st.general_reg_a);
    match_b = tick && (st.count == st.general_reg_b);
    if (tick) begin
      next_st.count = 16'(st.count + 16'h0001); // R12
    end
    unique case (st.mode)
      tcss_pkg::MODE_CAPTURE: begin
        if (cap_rise && st.count_start_bit) begin
          next_st.general_reg_a = st.count; // R8
          ev[tcss_pkg::FLAG_A_POS] = 1'b1; // R8
        end
      end
      tcss_pkg::MODE_COMPARE: begin
        if (match_b) begin
          ev[tcss_pkg::FLAG_B_POS] = 1'b1; // R9
          next_st.out_b = ~st.out_b; // R9
          next_st.count = tcss_pkg::COUNT_RST;
        end
      end
      default: begin
        // PWM: period in A, duty in B; active level is low
        if (match_a) begin
          ev[tcss_pkg::FLAG_A_POS] = 1'b1;
          next_st.count = tcss_pkg::COUNT_RST;
          next_st.out_b = 1'b0; // R11
        end else if (match_b) begin
          ev[tcss_pkg::FLAG_B_POS] = 1'b1;
          next_st.out_b = 1'b1; // R11
        end
      end
    endcase
    if (!legal && st.count_start_bit) begin
      ev[tcss_pkg::FLAG_ERR_POS] = 1'b1;
    end
    // Bus access: one wait state, answer on the second edge
    next_st.ack = (avs_read | avs_write) & ~st.ack;
    if (wr) begin
      unique case (avs_address)
        tcss_pkg::ADDR_CTRL: begin
          next_st.count_start_bit =
            avs_writedata[tcss_pkg::CTRL_START_POS];
          next_st.mode = avs_writedata[tcss_pkg::CTRL_MODE_POS +: 2];
          next_st.count_source_sel =
            avs_writedata[tcss_pkg::CTRL_SEL_POS +: 3];
          next_st.slow_clock_select_bit =
            avs_writedata[tcss_pkg::CTRL_SLOW_POS];
          next_st.hoco_freq_range_bit =
            avs_writedata[tcss_pkg::CTRL_FRQ_POS];
        end
        tcss_pkg::ADDR_GRA:  next_st.general_reg_a = avs_writedata[15:0];
        tcss_pkg::ADDR_GRB:  next_st.general_reg_b = avs_writedata[15:0];
        tcss_pkg::ADDR_MASK:
          next_st.mask = avs_writedata[tcss_pkg::FLAG_W-1:0];
        tcss_pkg::ADDR_COUNT: next_st.count = avs_writedata[15:0];
        tcss_pkg::ADDR_CLKCFG:
          next_st.cpu_clock_status_sel =
            avs_writedata[tcss_pkg::CPUSRC_POS +: 3];
        default: ;
      endcase
    end
    // Write-one-to-clear; a new event in the same cycle wins
    next_st.status = st.status;
    if (wr && avs_address == tcss_pkg::ADDR_STATUS) begin
      next_st.status = st.status & ~avs_writedata[tcss_pkg::FLAG_W-1:0]; // R10
    end
    next_st.status = next_st.status | ev;
    next_st.irq = |(next_st.status & next_st.mask);
    next_st.rdata = '0;
    if (rd) begin
      unique case (avs_address)
        tcss_pkg::ADDR_CTRL: next_st.rdata = {23'h0,
          st.hoco_freq_range_bit, st.slow_clock_select_bit,
          st.count_source_sel, 1'b0, st.mode, st.count_start_bit};
        tcss_pkg::ADDR_GRA:    next_st.rdata = {16'h0, st.general_reg_a};
        tcss_pkg::ADDR_GRB:    next_st.rdata = {16'h0, st.general_reg_b};
        tcss_pkg::ADDR_STATUS: next_st.rdata = {29'h0, st.status};
        tcss_pkg::ADDR_MASK:   next_st.rdata = {29'h0, st.mask};
        tcss_pkg::ADDR_COUNT:  next_st.rdata = {16'h0, st.count};
        tcss_pkg::ADDR_CLKCFG:
          next_st.rdata = {29'h0, st.cpu_clock_status_sel};
        default: next_st.rdata = '0;
      endcase
    end else begin
      next_st.rdata = st.rdata;
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st               <= '0;
      st.general_reg_a <= tcss_pkg::GR_RST;
      st.general_reg_b <= tcss_pkg::GR_RST;
      st.out_b         <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign avs_readdata             = st.rdata;
  assign avs_waitrequest          = ~st.ack;
  assign compare_output_b_pin_out = st.out_b;
  assign irq_out                  = st.irq;
endmodule
`default_nettype wire

// ---- verif/tcss_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module tcss_asserts (
  input wire logic        ref_clk_in,
  input wire logic        nrst_in,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        compare_output_b_pin_out,
  input wire logic        irq_out
);
  // Top bit of mask_q marks the mask as known, so reset value is no guess
  logic [3:0] mask_q;
  logic       run_q;
  wire        wr_done = avs_write && !avs_waitrequest;
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mask_q <= 4'h0;
      run_q  <= 1'b0;
    end else if (wr_done && avs_address == tcss_pkg::ADDR_MASK) begin
      mask_q <= {1'b1, avs_writedata[2:0]};
    end else if (wr_done && avs_address == tcss_pkg::ADDR_CTRL) begin
      run_q <= avs_writedata[0];
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_quiet;
    !run_q && !$past(run_q) && !wr_done && !$past(wr_done);
  endsequence
  property p_ans;
    s_req |=> !avs_waitrequest;
  endproperty
  property p_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  property p_cause;
    !avs_waitrequest |-> $past(avs_read) || $past(avs_write);
  endproperty
  property p_idle;
    !(avs_read || avs_write) && !$past(avs_read) && !$past(avs_write)
      |-> avs_waitrequest;
  endproperty
  property p_unm;
    avs_read && !avs_waitrequest && avs_address > 4'h6
      |-> avs_readdata == 32'h0000_0000;
  endproperty
  property p_rd;
    $changed(avs_readdata) |-> $past(avs_read);
  endproperty
  property p_irqm;
    mask_q == 4'h8 && $past(mask_q) == 4'h8 |-> !irq_out;
  endproperty
  property p_hold;
    s_quiet |-> $stable(compare_output_b_pin_out);
  endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  a_one: assert property (p_one) else $error("long ack");
  a_cause: assert property (p_cause) else $error("ack without request");
  a_idle: assert property (p_idle) else $error("idle ack");
  a_unm: assert property (p_unm) else $error("unmapped read nonzero");
  a_rd: assert property (p_rd) else $error("readdata moved");
  a_irqm: assert property (p_irqm) else $error("masked irq");
  a_hold: assert property (p_hold) else $error("output moved");
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        ref_clk_in = 1'b0;
  logic        nrst_in    = 1'b0;
  logic        avs_read   = 1'b0;
  logic        avs_write  = 1'b0;
  logic        ext_in     = 1'b0;
  logic        slow_in    = 1'b0;
  logic        cap_in     = 1'b0;
  logic [3:0]  avs_address   = 4'h0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  wire logic [31:0] avs_readdata;
  wire logic   avs_waitrequest;
  wire logic   cmp_out;
  wire logic   irq_out;
  int          n_fail = 0;
  int          cmp_count = 0;
  logic [31:0] lo_q[$];
  logic [31:0] hi_q[$];
  // Kind, cpu source, slow bit, range bit, select code
  logic [9:0]  tbl[12] = '{10'h005, 10'h025, 10'h045, 10'h065, 10'h085,
    10'h01d, 10'h110, 10'h198, 10'h255, 10'h275, 10'h209, 10'h212};
  tcss_timer dut (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ext_count_clock_pin_in(ext_in), .slow_clock_in(slow_in),
    .capture_in(cap_in), .compare_output_b_pin_out(cmp_out),
    .irq_out(irq_out));
  initial forever #25 ref_clk_in = !ref_clk_in;
  task automatic wt(input int c);
    repeat (c) @(posedge ref_clk_in);
  endtask
  task automatic chk(input string n, input logic [31:0] lo, hi, got);
    cmp_count++;
    if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1)) begin
      n_fail++;
      $display("mismatch %s exp %0h..%0h got %0h", n, lo, hi, got);
    end
  endtask
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    int t;
    t = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      wt(1);
      t++;
    end while (avs_waitrequest !== 1'b0 && t < 50);
    if (avs_waitrequest !== 1'b0) n_fail++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    wt(1);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] lo, hi);
    lo_q.push_back(lo);
    hi_q.push_back(hi);
    bus(a, 1'b0, 32'h0000_0000);
  endtask
  function automatic logic [31:0] ctl(input logic [2:0] s,
      input logic [1:0] m, input logic sl, fq, st);
    return {23'h0, fq, sl, s, 1'b0, m, st};
  endfunction
  // Ext rises once and slow twice per loop, so a wrong source shows
  task automatic pul(input int n);
    repeat (n) begin
      for (int p = 0; p < 4; p++) begin
        ext_in <= (p < 2);
        slow_in <= !p[0];
        wt(3 + $urandom % 3);
      end
    end
  endtask
  task automatic run(input logic [2:0] s, input logic [1:0] m, input int n);
    bus(tcss_pkg::ADDR_CTRL, 1, ctl(s, m, 0, 0, 1));
    pul(n);
    wt(4);
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge ref_clk_in) begin
    if (avs_read && avs_waitrequest === 1'b0)
      chk("readdata", lo_q.pop_front(), hi_q.pop_front(), avs_readdata);
  end
  initial begin
    wt(20000);
    n_fail++;
    wrap_up();
  end
  initial begin
    logic [9:0]  r;
    logic [31:0] b;
    logic [31:0] e;
    int          n;
    int          d;
    void'($urandom(32'hd0db));
    wt(20);
    nrst_in <= 1'b1;
    wt(1);
    chk("cmp", 1, 1, cmp_out);
    chk("irq", 0, 0, irq_out);
    rd(tcss_pkg::ADDR_GRA, tcss_pkg::GR_RST, tcss_pkg::GR_RST);
    rd(tcss_pkg::ADDR_COUNT, 0, 0);
    rd(4'hf, 0, 0);
    $display("reset test done");
    for (int c = 0; c < 5; c++) begin
      d = (c == 4) ? 32 : 1 << c;
      bus(tcss_pkg::ADDR_COUNT, 1, 0);
      bus(tcss_pkg::ADDR_CTRL, 1, ctl(c, 0, 0, 0, 1));
      wt(64);
      bus(tcss_pkg::ADDR_CTRL, 1, ctl(c, 0, 0, 0, 0));
      rd(tcss_pkg::ADDR_COUNT, 67 / d, (66 + d) / d);
    end
    $display("divider test done");
    bus(tcss_pkg::ADDR_MASK, 1, 4);
    foreach (tbl[i]) begin
      r = tbl[i];
      n = 2 + $urandom % 4;
      b = $urandom % 32'h0000_8000;
      bus(tcss_pkg::ADDR_CLKCFG, 1, r[7:5]);
      bus(tcss_pkg::ADDR_COUNT, 1, b);
      bus(tcss_pkg::ADDR_CTRL, 1, ctl(r[2:0], 0, r[4], r[3], 1));
      pul(n);
      wt(4);
      bus(tcss_pkg::ADDR_CTRL, 1, 0);
      e = b + (r[9] ? 0 : n << r[8]);
      rd(tcss_pkg::ADDR_COUNT, e, e);
      rd(tcss_pkg::ADDR_STATUS, r[9] << 2, r[9] << 2);
      chk("irq", r[9], r[9], irq_out);
      bus(tcss_pkg::ADDR_STATUS, 1, 7);
    end
    $display("source test done");
    bus(tcss_pkg::ADDR_MASK, 1, 0);
    bus(tcss_pkg::ADDR_COUNT, 1, 0);
    run(5, 0, 3);
    cap_in <= 1'b1;
    wt(4);
    cap_in <= 1'b0;
    wt(4);
    bus(tcss_pkg::ADDR_CTRL, 1, 0);
    rd(tcss_pkg::ADDR_GRA, 3, 3);
    chk("irq", 0, 0, irq_out);
    bus(tcss_pkg::ADDR_MASK, 1, 1);
    wt(2);
    chk("irq", 1, 1, irq_out);
    rd(tcss_pkg::ADDR_STATUS, 1, 1);
    bus(tcss_pkg::ADDR_STATUS, 1, 1);
    rd(tcss_pkg::ADDR_STATUS, 0, 0);
    chk("irq", 0, 0, irq_out);
    $display("capture test done");
    bus(tcss_pkg::ADDR_GRB, 1, 4);
    bus(tcss_pkg::ADDR_COUNT, 1, 0);
    // Counts 0 to 4, the fifth edge matches and reloads
    run(5, 1, 5);
    bus(tcss_pkg::ADDR_CTRL, 1, 0);
    chk("cmp", 0, 0, cmp_out);
    rd(tcss_pkg::ADDR_COUNT, 0, 0);
    rd(tcss_pkg::ADDR_STATUS, 2, 2);
    bus(tcss_pkg::ADDR_STATUS, 1, 7);
    $display("compare test done");
    bus(tcss_pkg::ADDR_GRA, 1, 6);
    bus(tcss_pkg::ADDR_GRB, 1, 2);
    // Output starts low from the compare test; B match at count 2 lifts it
    run(5, 2, 3);
    chk("cmp", 1, 1, cmp_out);
    rd(tcss_pkg::ADDR_CTRL, ctl(5, 2, 0, 0, 1), ctl(5, 2, 0, 0, 1));
    pul(4);
    wt(4);
    chk("cmp", 0, 0, cmp_out);
    pul(3);
    wt(4);
    chk("cmp", 1, 1, cmp_out);
    $display("pwm test done");
    wrap_up();
  end
endmodule
bind tcss_timer tcss_asserts u_chk (.ref_clk_in(ref_clk_in),
  .nrst_in(nrst_in), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .compare_output_b_pin_out(compare_output_b_pin_out), .irq_out(irq_out));
`default_nettype wire
